// ==== logic/ias_consts.svh ====
// Constants of the interrupt accept sequencer: levels, reset values, layouts
`ifndef IAS_CONSTS_SVH
`define IAS_CONSTS_SVH
`define IAS_LEVEL_W 5
`define IAS_MASK_W 4
`define IAS_NMI_LEVEL 5'h10
`define IAS_NMI_MASK 4'hf
`define IAS_RESET_PRIO 4'h0
`define IAS_RESET_MASK 4'hf
`define IAS_SR_MASK_LSB 4
`define IAS_VEC_BASE 8'h40
`define IAS_VEC_SHIFT 2
`define IAS_WORD_W 32
`define IAS_CNT_W 16
`endif

// ==== logic/ias_pkg.sv ====
// Types shared by both ends of the interrupt accept sequencer
package ias_pkg;
	typedef enum logic [1:0] {
		IAS_DTC_IDLE = 2'h0,
		IAS_DTC_REQ = 2'h1,
		IAS_DTC_GAP = 2'h3
	} ias_dtc_state_t;
	typedef enum logic [1:0] {
		IAS_CPU_RUN = 2'h0,
		IAS_CPU_PUSH_SR = 2'h1,
		IAS_CPU_PUSH_PC = 2'h3,
		IAS_CPU_VECTOR = 2'h2
	} ias_cpu_state_t;
endpackage

// ==== logic/ias_link_if.sv ====
// Link between the interrupt controller and the CPU core with transfer controller
`timescale 1ns/1ps
`default_nettype none
`include "ias_consts.svh"
interface ias_link_if #(parameter int IW = 4);
	logic irq_req;
	logic [`IAS_LEVEL_W-1:0] irq_level;
	logic [IW-1:0] irq_idx;
	logic exc_start;
	logic [IW-1:0] taken_idx;
	logic [`IAS_MASK_W-1:0] mask_level;
	logic dtc_req;
	logic [IW-1:0] dtc_src;
	logic dtc_done;
	logic dtc_count_zero;
	logic xfer_en_set;
	logic [IW-1:0] xfer_en_src;
	modport dev (output irq_req, irq_level, irq_idx, dtc_req, dtc_src,
		input exc_start, taken_idx, mask_level, dtc_done, dtc_count_zero, xfer_en_set, xfer_en_src);
	modport cpu (input irq_req, irq_level, irq_idx, dtc_req, dtc_src,
		output exc_start, taken_idx, mask_level, dtc_done, dtc_count_zero, xfer_en_set, xfer_en_src);
endinterface
`default_nettype wire

// ==== logic/ias_prio_arbiter.sv ====
// Picks the highest level request; on equal levels the lowest index wins
`timescale 1ns/1ps
`default_nettype none
`include "ias_consts.svh"
module ias_prio_arbiter
	import ias_pkg::*;
#(
	parameter int N = 8,
	parameter int IW = 3
) (
	input wire logic [N-1:0] req_i,
	input wire logic [N*`IAS_LEVEL_W-1:0] level_i,
	output logic valid_o,
	output logic [IW-1:0] idx_o,
	output logic [`IAS_LEVEL_W-1:0] level_o
);
	logic [`IAS_LEVEL_W-1:0] lv;
	// Scan downward with >= so the lower index takes ties; level zero is masked
	always_comb begin
		valid_o = 1'b0;
		idx_o = '0;
		level_o = '0;
		lv = '0;
		for (int i = N - 1; i >= 0; i--) begin
			lv = level_i[i*`IAS_LEVEL_W +: `IAS_LEVEL_W];
			if (req_i[i] && (lv != '0) && (lv >= level_o)) begin
				valid_o = 1'b1;
				idx_o = IW'(i);
				level_o = lv;
			end
		end
	end
endmodule
`default_nettype wire

// ==== logic/ias_interrupt_controller.sv ====
// Interrupt controller end: arbitration, acceptance, pending pin, transfer routing
// Operation
// - Select highest programmed priority among requests
// - Equal levels resolved by fixed vector order
// - Accept only when level exceeds mask
// - Accept raises CPU request, pin low
// - CPU takes request at instruction decode
// - CPU pushes status word and PC
// - CPU loads accepted level into mask
// - Level/peripheral request: pin high once taken
// - Edge request: pin high when exception starts
// - Higher accepted request keeps pin low
// - CPU jumps to vector, no delay slot
// - Edge requests held pending until accepted
// - Software may withdraw pending pin request
// - Any reset discards pending edge requests
// - Transfer enable routes request to transfer controller
// - Transfer enable cleared only at transfer end
// - Select set: clear enable, raise CPU request
// - Select clear: clear source flag, no request
// - Count zero: clear enable, forward request
// - Enable clear: request goes to CPU
// - Handler clears flag, re-enables on nonzero count
// - Reset sets all source levels to zero
// - Levels 0 to 15, NMI 16
`timescale 1ns/1ps
`default_nettype none
`include "ias_consts.svh"
module ias_interrupt_controller
	import ias_pkg::*;
#(
	parameter int NPIN = 4,
	parameter int NPER = 3,
	parameter int NSRC = 1 + NPIN + NPER,
	parameter int IW = $clog2(NSRC)
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic manual_reset_i,
	ias_link_if.dev link,
	input wire logic nmi_n_i,
	input wire logic [NPIN-1:0] ext_req_n_i,
	input wire logic [NPIN-1:0] pin_edge_mode_i,
	input wire logic [NPIN-1:0] pin_withdraw_i,
	output logic [NPIN-1:0] pin_status_o,
	input wire logic [NPER-1:0] per_req_i,
	output logic [NPER-1:0] per_flag_clr_o,
	input wire logic prio_wr_i,
	input wire logic [IW-1:0] prio_wr_idx_i,
	input wire logic [`IAS_MASK_W-1:0] prio_wr_data_i,
	input wire logic [NPER-1:0] irq_after_xfer_select_i,
	output logic [NPER-1:0] xfer_en_o,
	output logic request_pending_out_n_o
);
	localparam int NS = NPIN + 1;
	localparam int PB = NPIN + 1;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: NMI at index 0, external pins above it
	logic [NS-1:0] raw_n;
	logic [NS-1:0] s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;
	assign raw_n = {ext_req_n_i, nmi_n_i};
	// Three stages; a level counts once the second and third agree
	always_comb begin
		filt_d = filt_q;
		for (int i = 0; i < NS; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				filt_d[i] = s3_q[i];
			end
		end
	end
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
			filt_q <= '1;
			prev_q <= '1;
		end else begin
			s1_q <= raw_n;
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
			prev_q <= filt_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Priority registers, edge pending flags and transfer enables
	logic [`IAS_MASK_W-1:0] prio_q [NSRC];
	logic [`IAS_MASK_W-1:0] prio_d [NSRC];
	logic [NS-1:0] pend_q, pend_d, fall;
	logic [NPER-1:0] xen_q, xen_d, fclr_q, fclr_d;
	logic [NSRC-1:0] req;
	logic [NSRC*`IAS_LEVEL_W-1:0] lvl;
	logic take;
	logic win_valid;
	logic [IW-1:0] win_idx;
	logic [`IAS_LEVEL_W-1:0] win_level;
	ias_dtc_state_t dst_q, dst_d;
	logic [IW-1:0] dsrc_q, dsrc_d;
	logic [NPER-1:0] dtc_cand;

	assign fall = prev_q & ~filt_q;
	assign take = link.exc_start;

	// Request vector and level vector handed to the arbiter
	always_comb begin
		req = '0;
		lvl = '0;
		req[0] = pend_q[0];
		lvl[0 +: `IAS_LEVEL_W] = `IAS_NMI_LEVEL;
		for (int i = 1; i < NSRC; i++) begin
			lvl[i*`IAS_LEVEL_W +: `IAS_LEVEL_W] = {1'b0, prio_q[i]};
		end
		for (int i = 0; i < NPIN; i++) begin
			req[i+1] = pin_edge_mode_i[i] ? pend_q[i+1] : ~filt_q[i+1];
		end
		for (int j = 0; j < NPER; j++) begin
			req[PB+j] = per_req_i[j] & ~xen_q[j];
		end
	end

	ias_prio_arbiter #(
		.N(NSRC),
		.IW(IW)
	) u_arb (
		.req_i(req),
		.level_i(lvl),
		.valid_o(win_valid),
		.idx_o(win_idx),
		.level_o(win_level)
	);

	// Next values of levels, pending flags and transfer enables
	always_comb begin
		prio_d = prio_q;
		pend_d = pend_q;
		xen_d = xen_q;
		fclr_d = '0;
		if (prio_wr_i && (prio_wr_idx_i != '0) && (32'(prio_wr_idx_i) < NSRC)) begin
			prio_d[prio_wr_idx_i] = prio_wr_data_i;
		end
		for (int i = 0; i < NS; i++) begin
			if (manual_reset_i) begin
				pend_d[i] = 1'b0;
			end else if (fall[i] && (i == 0 || pin_edge_mode_i[i-1])) begin
				pend_d[i] = 1'b1;
			end else if (take && (32'(link.taken_idx) == i)) begin
				pend_d[i] = 1'b0;
			end else if (i > 0 && pin_withdraw_i[i-1]) begin
				pend_d[i] = 1'b0;
			end
		end
		if (dst_q == IAS_DTC_REQ && link.dtc_done) begin
			for (int j = 0; j < NPER; j++) begin
				if (32'(dsrc_q) == j) begin
					if (irq_after_xfer_select_i[j] || link.dtc_count_zero) begin
						xen_d[j] = 1'b0;
					end else begin
						fclr_d[j] = 1'b1;
					end
				end
			end
		end
		for (int j = 0; j < NPER; j++) begin
			if (link.xfer_en_set && (32'(link.xfer_en_src) == j)) begin
				xen_d[j] = 1'b1;
			end
		end
	end
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < NSRC; i++) begin
				prio_q[i] <= `IAS_RESET_PRIO;
			end
			pend_q <= '0;
			xen_q <= '0;
			fclr_q <= '0;
		end else begin
			prio_q <= prio_d;
			pend_q <= pend_d;
			xen_q <= xen_d;
			fclr_q <= fclr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transfer controller activation: one transfer at a time, gap after each
	always_comb begin
		dst_d = dst_q;
		dsrc_d = dsrc_q;
		dtc_cand = per_req_i & xen_q;
		unique case (dst_q)
			IAS_DTC_IDLE: begin
				for (int j = NPER - 1; j >= 0; j--) begin
					if (dtc_cand[j]) begin
						dsrc_d = IW'(j);
						dst_d = IAS_DTC_REQ;
					end
				end
			end
			IAS_DTC_REQ: begin
				if (link.dtc_done) begin
					dst_d = IAS_DTC_GAP;
				end
			end
			IAS_DTC_GAP: begin
				dst_d = IAS_DTC_IDLE; // Lets the flag clear reach the source
			end
			default: begin
				dst_d = IAS_DTC_IDLE;
			end
		endcase
	end
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dst_q <= IAS_DTC_IDLE;
			dsrc_q <= '0;
		end else begin
			dst_q <= dst_d;
			dsrc_q <= dsrc_d;
		end
	end
	assign link.dtc_req = (dst_q == IAS_DTC_REQ);
	assign link.dtc_src = dsrc_q;

	////////////////////////////////////////////////////////////////////////
	// Acceptance against the CPU mask and the pending-request pin
	logic acc, irq_q, irq_d, pin_n_q, pin_n_d;
	logic [`IAS_LEVEL_W-1:0] ilvl_q, ilvl_d;
	logic [IW-1:0] iidx_q, iidx_d;
	always_comb begin
		acc = win_valid && (win_level > {1'b0, link.mask_level});
		// The source being taken this cycle is released; a different winner stays
		irq_d = acc && !(take && (win_idx == link.taken_idx));
		pin_n_d = ~irq_d;
		ilvl_d = irq_d ? win_level : ilvl_q;
		iidx_d = irq_d ? win_idx : iidx_q;
	end
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_q <= 1'b0;
			pin_n_q <= 1'b1;
			ilvl_q <= '0;
			iidx_q <= '0;
		end else begin
			irq_q <= irq_d;
			pin_n_q <= pin_n_d;
			ilvl_q <= ilvl_d;
			iidx_q <= iidx_d;
		end
	end

	assign link.irq_req = irq_q;
	assign link.irq_level = ilvl_q;
	assign link.irq_idx = iidx_q;
	assign request_pending_out_n_o = pin_n_q;
	assign xfer_en_o = xen_q;
	assign per_flag_clr_o = fclr_q;
	// Status view: held flag in edge mode, live level otherwise
	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			pin_status_o[i] = pin_edge_mode_i[i] ? pend_q[i+1] : ~filt_q[i+1];
		end
	end
endmodule
`default_nettype wire

// ==== logic/ias_cpu.sv ====
// CPU core and transfer controller end: exception entry and transfer execution
`timescale 1ns/1ps
`default_nettype none
`include "ias_consts.svh"
module ias_cpu
	import ias_pkg::*;
#(
	parameter int IW = 3
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	ias_link_if.cpu link,
	input wire logic insn_decode_i,
	input wire logic [`IAS_WORD_W-1:0] pc_i,
	input wire logic mask_wr_i,
	input wire logic [`IAS_MASK_W-1:0] mask_wr_data_i,
	output logic [`IAS_WORD_W-1:0] cpu_status_word_o,
	output logic exc_busy_o,
	output logic stack_wr_o,
	output logic [`IAS_WORD_W-1:0] stack_data_o,
	output logic [`IAS_WORD_W-1:0] vec_addr_o,
	input wire logic [`IAS_WORD_W-1:0] vec_rd_i,
	output logic jump_o,
	output logic [`IAS_WORD_W-1:0] jump_pc_o,
	input wire logic cnt_load_i,
	input wire logic [`IAS_CNT_W-1:0] cnt_value_i,
	output logic [`IAS_CNT_W-1:0] count_o,
	input wire logic soft_rearm_i,
	input wire logic [IW-1:0] rearm_src_i,
	output logic src_flag_clr_o,
	output logic [IW-1:0] src_flag_clr_idx_o
);
	ias_cpu_state_t st_q, st_d;
	logic [`IAS_MASK_W-1:0] mask_q, mask_d;
	logic [`IAS_WORD_W-1:0] sr_old_q, sr_old_d, pc_q, pc_d, sd_q, sd_d, jpc_q, jpc_d;
	logic [IW-1:0] tidx_q, tidx_d;
	logic swr_q, swr_d, jmp_q, jmp_d, take;

	// Take the request at decode in place of that instruction
	assign take = (st_q == IAS_CPU_RUN) && insn_decode_i && link.irq_req;
	always_comb begin
		st_d = st_q;
		mask_d = mask_q;
		sr_old_d = sr_old_q;
		pc_d = pc_q;
		tidx_d = tidx_q;
		sd_d = sd_q;
		swr_d = 1'b0;
		jpc_d = jpc_q;
		jmp_d = 1'b0;
		unique case (st_q)
			IAS_CPU_RUN: begin
				if (take) begin
					sr_old_d = cpu_status_word_o;
					pc_d = pc_i;
					tidx_d = link.irq_idx;
					// NMI level 16 does not fit the mask field and becomes 15
					mask_d = link.irq_level[`IAS_LEVEL_W-1] ? `IAS_NMI_MASK
						: link.irq_level[`IAS_MASK_W-1:0];
					st_d = IAS_CPU_PUSH_SR;
				end else if (mask_wr_i) begin
					mask_d = mask_wr_data_i;
				end
			end
			IAS_CPU_PUSH_SR: begin
				sd_d = sr_old_q;
				swr_d = 1'b1;
				st_d = IAS_CPU_PUSH_PC;
			end
			IAS_CPU_PUSH_PC: begin
				sd_d = pc_q;
				swr_d = 1'b1;
				st_d = IAS_CPU_VECTOR;
			end
			IAS_CPU_VECTOR: begin
				jpc_d = vec_rd_i;
				jmp_d = 1'b1;
				st_d = IAS_CPU_RUN;
			end
		endcase
	end
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q <= IAS_CPU_RUN;
			mask_q <= `IAS_RESET_MASK;
			sr_old_q <= '0;
			pc_q <= '0;
			tidx_q <= '0;
			sd_q <= '0;
			swr_q <= 1'b0;
			jpc_q <= '0;
			jmp_q <= 1'b0;
		end else begin
			st_q <= st_d;
			mask_q <= mask_d;
			sr_old_q <= sr_old_d;
			pc_q <= pc_d;
			tidx_q <= tidx_d;
			sd_q <= sd_d;
			swr_q <= swr_d;
			jpc_q <= jpc_d;
			jmp_q <= jmp_d;
		end
	end
	assign link.exc_start = take;
	assign link.taken_idx = link.irq_idx;
	assign link.mask_level = mask_q;
	assign cpu_status_word_o = `IAS_WORD_W'({mask_q, `IAS_SR_MASK_LSB'(0)});
	assign exc_busy_o = (st_q != IAS_CPU_RUN);
	assign stack_wr_o = swr_q;
	assign stack_data_o = sd_q;
	assign vec_addr_o = `IAS_WORD_W'({(`IAS_VEC_BASE + 8'(tidx_q)), `IAS_VEC_SHIFT'(0)});
	assign jump_o = jmp_q;
	assign jump_pc_o = jpc_q;

	////////////////////////////////////////////////////////////////////////
	// Transfer controller: one cycle per transfer, then the handler re-arm path
	logic [`IAS_CNT_W-1:0] cnt_q, cnt_d;
	logic done_q, done_d, zero_q, zero_d, ren_q, ren_d, fc_q, fc_d;
	logic [IW-1:0] rsrc_q, rsrc_d;
	always_comb begin
		cnt_d = cnt_q;
		done_d = link.dtc_req & ~done_q;
		zero_d = zero_q;
		ren_d = 1'b0;
		fc_d = 1'b0;
		rsrc_d = rsrc_q;
		if (cnt_load_i) begin
			cnt_d = cnt_value_i;
		end else if (done_d) begin
			cnt_d = (cnt_q == '0) ? cnt_q : cnt_q - `IAS_CNT_W'(1);
			zero_d = (cnt_q <= `IAS_CNT_W'(1));
		end
		if (soft_rearm_i) begin
			fc_d = 1'b1;
			rsrc_d = rearm_src_i;
			ren_d = (cnt_q != '0);
		end
	end
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_q <= '0;
			done_q <= 1'b0;
			zero_q <= 1'b0;
			ren_q <= 1'b0;
			fc_q <= 1'b0;
			rsrc_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			done_q <= done_d;
			zero_q <= zero_d;
			ren_q <= ren_d;
			fc_q <= fc_d;
			rsrc_q <= rsrc_d;
		end
	end
	assign link.dtc_done = done_q;
	assign link.dtc_count_zero = zero_q;
	assign link.xfer_en_set = ren_q;
	assign link.xfer_en_src = rsrc_q;
	assign count_o = cnt_q;
	assign src_flag_clr_o = fc_q;
	assign src_flag_clr_idx_o = rsrc_q;
endmodule
`default_nettype wire

// ==== bench/ias_link_assertions.sv ====
// Checker of the link between the interrupt controller end and the CPU end
`timescale 1ns/1ps
`default_nettype none
`include "ias_consts.svh"
module ias_link_assertions #(
	parameter int IW = 3
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic irq_req,
	input wire logic [`IAS_LEVEL_W-1:0] irq_level,
	input wire logic [IW-1:0] irq_idx,
	input wire logic exc_start,
	input wire logic [`IAS_MASK_W-1:0] mask_level,
	input wire logic dtc_req,
	input wire logic dtc_done,
	input wire logic xfer_en_set
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	// Low nibble of the level, for the mask load check
	logic [3:0] lvl_low;
	assign lvl_low = irq_level[3:0];
	////////////////////////////////////////////////////////////////////////////////
	property p_above_mask;
		irq_req && $stable(mask_level) |-> irq_level > {1'b0, mask_level};
	endproperty
	a_above_mask: assert property (p_above_mask) else $error("request not above mask");
	property p_mask_load;
		exc_start |=> mask_level == (($past(irq_level) == `IAS_NMI_LEVEL) ? `IAS_NMI_MASK : $past(lvl_low));
	endproperty
	a_mask_load: assert property (p_mask_load) else $error("mask not loaded");
	property p_release;
		exc_start |=> !irq_req || irq_idx != $past(irq_idx);
	endproperty
	a_release: assert property (p_release) else $error("taken request not released");
	property p_exc_gap;
		exc_start |=> !exc_start [*3];
	endproperty
	a_exc_gap: assert property (p_exc_gap) else $error("entry restarted too soon");
	property p_nmi_level;
		irq_req && irq_idx == '0 |-> irq_level == `IAS_NMI_LEVEL;
	endproperty
	a_nmi_level: assert property (p_nmi_level) else $error("wrong level for index 0");
	property p_level_zero;
		irq_req |-> irq_level != '0;
	endproperty
	a_level_zero: assert property (p_level_zero) else $error("level zero accepted");
	property p_dtc_answer;
		$rose(dtc_req) |=> dtc_done;
	endproperty
	a_dtc_answer: assert property (p_dtc_answer) else $error("transfer not done");
	property p_dtc_gap;
		dtc_done |=> !dtc_req [*2];
	endproperty
	a_dtc_gap: assert property (p_dtc_gap) else $error("no gap after transfer");
	property p_done_cause;
		dtc_done |-> $past(dtc_req);
	endproperty
	a_done_cause: assert property (p_done_cause) else $error("done without request");
	property p_rearm;
		xfer_en_set |=> !xfer_en_set;
	endproperty
	a_rearm: assert property (p_rearm) else $error("rearm not a pulse");
endmodule
`default_nettype wire

// ==== bench/interrupt_accept_sequencer_test.sv ====
// Testbench of both ends of the interrupt accept sequencer
`timescale 1ns/1ps
`default_nettype none
module interrupt_accept_sequencer_test;
	logic clk = 0, arst_n = 0, man_rst = 0, nmi_n = 1, prio_wr = 0, dec = 0, mask_wr = 0, cnt_ld = 0, rearm = 0;
	logic [3:0] ext_n = 4'hf, edge_md = 4'h0, wdraw = 4'h0, prio_dat = 4'h0, mask_dat = 4'h0, cur_mask = 4'hf;
	logic [2:0] per_req = 3'h0, sel = 3'h0, prio_idx = 3'h0, flag_clr, xfer_en, fclr_idx;
	logic [3:0] pin_stat;
	logic [15:0] cnt_val = 16'h0, cnt;
	logic [31:0] pc = 32'h0000_2000, vec = 32'h0000_1230, sr, stk_d, vaddr, jpc;
	logic pend_n, busy, stk_wr, jmp, fclr;
	int num_errors = 0, cmp_count = 0, cycles = 0;
	ias_link_if #(.IW(3)) link();
	ias_interrupt_controller i_ias_interrupt_controller (.sys_clk_i(clk), .arst_n_i(arst_n), .manual_reset_i(man_rst), .link(link), .nmi_n_i(nmi_n),
		.ext_req_n_i(ext_n), .pin_edge_mode_i(edge_md), .pin_withdraw_i(wdraw), .pin_status_o(pin_stat),
		.per_req_i(per_req), .per_flag_clr_o(flag_clr), .prio_wr_i(prio_wr), .prio_wr_idx_i(prio_idx),
		.prio_wr_data_i(prio_dat), .irq_after_xfer_select_i(sel), .xfer_en_o(xfer_en), .request_pending_out_n_o(pend_n));
	ias_cpu #(.IW(3)) i_ias_cpu (.sys_clk_i(clk), .arst_n_i(arst_n), .link(link), .insn_decode_i(dec), .pc_i(pc),
		.mask_wr_i(mask_wr), .mask_wr_data_i(mask_dat), .cpu_status_word_o(sr), .exc_busy_o(busy), .stack_wr_o(stk_wr),
		.stack_data_o(stk_d), .vec_addr_o(vaddr), .vec_rd_i(vec), .jump_o(jmp), .jump_pc_o(jpc), .cnt_load_i(cnt_ld),
		.cnt_value_i(cnt_val), .count_o(cnt), .soft_rearm_i(rearm), .rearm_src_i(3'h2), .src_flag_clr_o(fclr),
		.src_flag_clr_idx_o(fclr_idx));
	ias_link_assertions #(.IW(3)) i_ias_link_assertions (.sys_clk_i(clk), .arst_n_i(arst_n), .irq_req(link.irq_req),
		.irq_level(link.irq_level), .irq_idx(link.irq_idx), .exc_start(link.exc_start), .mask_level(link.mask_level),
		.dtc_req(link.dtc_req), .dtc_done(link.dtc_done), .xfer_en_set(link.xfer_en_set));
	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Software write of the CPU mask or of one source level
	task automatic wr(input logic m, input logic [2:0] i, input logic [3:0] d);
		@(posedge clk);
		prio_wr <= !m;
		mask_wr <= m;
		prio_idx <= i;
		prio_dat <= d;
		mask_dat <= d;
		@(posedge clk);
		prio_wr <= 1'b0;
		mask_wr <= 1'b0;
		if (m) cur_mask = d;
	endtask
	task automatic wait_irq(input logic [2:0] id, input logic [4:0] lv);
		int k = 0;
		@(negedge clk);
		while (link.irq_req !== 1'b1 && k < 12) begin
			@(negedge clk);
			k++;
		end
		chk(link.irq_idx, id);
		chk(link.irq_level, lv);
		chk(pend_n, 1'b0);
	endtask
	// Exception entry: status word, then PC, then jump to the vector
	task automatic take(input logic [2:0] id, input logic [3:0] nm);
		@(posedge clk);
		dec <= 1'b1;
		@(negedge clk);
		chk(link.exc_start, 1'b1);
		@(posedge clk);
		dec <= 1'b0;
		@(negedge clk);
		chk(sr, {24'h0, nm, 4'h0});
		chk(pend_n, 1'b1);
		chk(vaddr, (32'h40 + id) * 4);
		chk(busy, 1'b1);
		@(negedge clk);
		chk(stk_wr, 1'b1);
		chk(stk_d, {24'h0, cur_mask, 4'h0});
		@(negedge clk);
		chk(stk_d, pc);
		@(negedge clk);
		chk(jmp, 1'b1);
		chk(jpc, vec);
		chk(busy, 1'b0);
		cur_mask = nm;
	endtask
	task automatic pin_edge();
		@(posedge clk);
		ext_n[0] <= 1'b0;
		repeat (2) @(posedge clk);
		ext_n[0] <= 1'b1;
	endtask
	task automatic ctl(input logic w, input logic m);
		@(posedge clk);
		wdraw[0] <= w;
		man_rst <= m;
		@(posedge clk);
		wdraw[0] <= 1'b0;
		man_rst <= 1'b0;
		repeat (2) @(negedge clk);
		chk(pin_stat[0], 1'b0);
		chk(pend_n, 1'b1);
	endtask
	// Load the count, then re-arm transfer enable of the last peripheral
	task automatic arm(input logic [15:0] n);
		@(posedge clk);
		cnt_ld <= 1'b1;
		cnt_val <= n;
		@(posedge clk);
		cnt_ld <= 1'b0;
		rearm <= 1'b1;
		@(posedge clk);
		rearm <= 1'b0;
		@(negedge clk);
		chk(fclr, 1'b1);
		chk(fclr_idx, 3'h2);
		@(negedge clk);
		chk(xfer_en[2], 1'b1);
	endtask
	// One request of the last peripheral; its flag drops after the flag clear or the CPU request
	task automatic xfer(input logic irq);
		int k = 0;
		@(posedge clk);
		per_req <= 3'b100;
		@(negedge clk);
		while (flag_clr[2] !== 1'b1 && link.irq_req !== 1'b1 && k < 10) begin
			@(negedge clk);
			k++;
		end
		chk(link.irq_req, irq);
		chk(xfer_en[2], !irq);
		chk(flag_clr[2], !irq);
		chk(link.dtc_src, 3'h2);
		@(posedge clk);
		per_req <= 3'b000;
		// Let a request from this call die out so the next call starts clean
		repeat (2) @(negedge clk);
		chk(link.irq_req, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		chk(pend_n, 1'b1);
		chk(sr, 32'h0000_00f0);
		chk({xfer_en, pin_stat}, 7'h00);
		wr(1'b1, 3'h0, 4'h0);
		wr(1'b0, 3'h5, 4'h3);
		wr(1'b0, 3'h6, 4'h7);
		@(posedge clk);
		per_req <= 3'b011;
		wait_irq(3'h6, 5'h07);
		wr(1'b0, 3'h5, 4'h7);
		repeat (2) @(negedge clk);
		chk(link.irq_idx, 3'h5);
		take(3'h5, 4'h7);
		repeat (2) @(negedge clk);
		chk(link.irq_req, 1'b0);
		wr(1'b0, 3'h1, 4'h6);
		@(posedge clk);
		per_req <= 3'b000;
		edge_md <= 4'h1;
		pin_edge();
		repeat (6) @(negedge clk);
		chk({pin_stat[0], pend_n}, 2'b11);
		wr(1'b1, 3'h0, 4'h5);
		wait_irq(3'h1, 5'h06);
		ctl(1'b1, 1'b0);
		pin_edge();
		wait_irq(3'h1, 5'h06);
		ctl(1'b0, 1'b1);
		wr(1'b1, 3'h0, 4'hf);
		@(posedge clk);
		nmi_n <= 1'b0;
		wait_irq(3'h0, 5'h10);
		take(3'h0, 4'hf);
		@(posedge clk);
		nmi_n <= 1'b1;
		wr(1'b1, 3'h0, 4'h0);
		wr(1'b0, 3'h7, 4'h4);
		arm(16'h0005);
		xfer(1'b0);
		chk(cnt, 16'h0004);
		@(posedge clk);
		sel <= 3'b100;
		xfer(1'b1);
		chk(cnt, 16'h0003);
		@(posedge clk);
		sel <= 3'b000;
		arm(16'h0001);
		xfer(1'b1);
		chk(cnt, 16'h0000);
		xfer(1'b1);
		chk(cnt, 16'h0000);
		give_verdict();
	end
endmodule
`default_nettype wire
